// file: lia_fast_a20.sv
// Hardware decoder of gate commands written to channel 1
`timescale 1ns/1ps
`default_nettype none
module lia_fast_a20
    import lia_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    // Host writes to channel 1
    input  wire logic       enable,
    input  wire logic       wrStb,
    input  wire logic       isCmd,
    input  wire logic [7:0] data,
    // Results
    output logic            absorb,
    output logic            gate
);
    lia_a20_e st_q;
    lia_a20_e stD;
    logic     gate_q;

    // Bytes of the sequence never reach firmware
    always_comb begin
        stD    = st_q;
        absorb = 1'b0;
        if (enable && wrStb) begin
            if (isCmd && data == CMD_A20) begin
                stD    = A_WAIT;
                absorb = 1'b1;
            end else if (!isCmd && st_q == A_WAIT) begin
                stD    = A_DONE;
                absorb = 1'b1;
            end else if (isCmd && data == CMD_NULL && st_q == A_DONE) begin
                stD    = A_IDLE;
                absorb = 1'b1;
            end else begin
                stD    = A_IDLE;
            end
        end
    end

    // Disabled decoder stays idle so every byte goes to firmware
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= A_IDLE;
        end else if (!enable) begin
            st_q <= A_IDLE;
        end else begin
            st_q <= stD;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            gate_q <= GATE_RST;
        end else if (enable && wrStb && !isCmd && st_q == A_WAIT) begin
            gate_q <= data[A20_BIT];
        end
    end

    assign gate = gate_q;

    AST_GATE_FROM_DATA: assert property (@(posedge sys_clk) disable iff (!arst_n)
        enable && wrStb && !isCmd && st_q == A_WAIT |=> gate_q == $past(data[A20_BIT]))
        else $error("gate did not follow data bit");
    AST_CANCEL_KEEPS_GATE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wrStb && isCmd && st_q == A_WAIT |=> $stable(gate_q))
        else $error("command changed gate");
endmodule : lia_fast_a20
`default_nettype wire

// file: lia_lpc_host.sv
// LPC host model that frames cycles on the link
`timescale 1ns/1ps
`default_nettype none
module lia_lpc_host (
    // Link driven by the host
    output logic            lclk,
    output logic            lframeN,
    output logic [3:0]      ladIn,
    // Slave drive
    input  wire logic [3:0] ladOut,
    input  wire logic       ladOeN
);
    logic [3:0] drv;
    logic [3:0] seen [1:13];
    // Released lines float to 1111 through the pull-ups
    assign ladIn = ladOeN ? drv : ladOut;
    initial begin
        lclk = 1'b0;
        lframeN = 1'b1;
        drv = 4'hf;
        #200;
        forever #62.5 lclk = ~lclk;
    end
    // Nonzero abortAt pulls the frame low again in that state
    task automatic xfer(input logic [3:0] typ, input logic [15:0] a, input logic [7:0] d, input int abortAt);
        for (int s = 1; s <= 13; s++) begin
            @(negedge lclk);
            lframeN = !(s == 1 || s == abortAt);
            case (s)
                1: drv = 4'h0;
                2: drv = typ;
                3, 4, 5, 6: drv = a[(6 - s) * 4 +: 4];
                7: drv = (typ == 4'h2) ? d[3:0] : 4'hf;
                8: drv = (typ == 4'h2) ? d[7:4] : 4'hf;
                default: drv = 4'hf;
            endcase
            @(posedge lclk);
            seen[s] = ladIn;
        end
    endtask : xfer
endmodule : lia_lpc_host
`default_nettype wire

// file: lia_lpc_io_slave.sv
// LPC I/O read and write slave with host channels and fast A20 gate
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module lia_lpc_io_slave
    import lia_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWe,
    input  wire logic        regRe,
    output logic      [31:0] regRdata,
    // LPC link
    input  wire logic        lclk,
    input  wire logic        lframeN,
    input  wire logic [3:0]  ladIn,
    output logic      [3:0]  ladOut,
    output logic             ladOeN,
    // Gate pin and interrupt
    output logic             a20PortPin,
    output logic             irq
);
    // Link inputs, {lclk, lframeN, ladIn}
    logic [5:0]  inS1_q;
    logic [5:0]  inS2_q;
    logic [5:0]  inS3_q;
    logic        lclkRise;
    logic        frameLow;
    logic [3:0]  ladNib;
    // Cycle sequencer
    lia_st_e     st_q;
    lia_st_e     stD;
    logic [1:0]  cnt_q;
    logic [15:0] addr_q;
    logic [15:0] addrFull;
    logic        isWr_q;
    logic        isCmd_q;
    logic        chSel_q;
    logic [7:0]  wByte_q;
    logic [7:0]  rByte_q;
    logic        busy_q;
    logic        commit;
    logic        addrDone;
    logic [3:0]  ladOut_q;
    logic        ladOeN_q;
    // Channels
    logic [NCH-1:0] hit;
    logic [NCH-1:0] hostWr;
    logic [NCH-1:0] deliver;
    logic [NCH-1:0] hostRdData;
    logic [NCH-1:0] ibf_q;
    logic [NCH-1:0] obf_q;
    logic [NCH-1:0] cd_q;
    logic [7:0]     idr_q  [NCH];
    logic [7:0]     odr_q  [NCH];
    logic [7:0]     strB   [NCH];
    logic [15:0]    base_q [NCH];
    logic [31:0]    chRd   [NCH];
    // Local registers
    logic [3:0]     ctrl_q;
    logic [NCH-1:0] irqSt_q;
    logic [NCH-1:0] irqMsk_q;
    logic           irqRd;
    logic [31:0]    rdMux;
    logic [31:0]    regRdata_q;
    logic           a20Pin_q;
    logic           irq_q;
    logic           a20Absorb;
    logic           a20Gate;

    // Link pins come from the host clock domain
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            inS1_q <= 6'h3f;
            inS2_q <= 6'h3f;
            inS3_q <= 6'h3f;
        end else begin
            inS1_q <= {lclk, lframeN, ladIn};
            inS2_q <= inS1_q;
            inS3_q <= inS2_q;
        end
    end

    // Data taken one stage late was settled before the host edge
    assign lclkRise = inS2_q[5] & ~inS3_q[5];
    assign frameLow = ~inS3_q[4];
    assign ladNib   = inS3_q[3:0];
    assign addrFull = {addr_q[11:0], ladNib};

    // Host address decode, data port at base, command and status at base plus 4
    generate
        for (genvar c = 0; c < NCH; c++) begin : g_hit
            assign hit[c] = ctrl_q[CTRL_EN + c]
                          && addrFull[15:3] == base_q[c][15:3]
                          && addrFull[1:0] == 2'b00;
        end
    endgenerate

    assign addrDone = st_q == ST_ADDR && cnt_q == 2'd3;

    always_comb begin
        stD = st_q;
        if (frameLow) begin
            stD = (ladNib == NIB_START) ? ST_TYPE : ST_IDLE;
        end else begin
            case (st_q)
                ST_TYPE: begin
                    if (ladNib == NIB_IO_RD || ladNib == NIB_IO_WR) begin
                        stD = ST_ADDR;
                    end else begin
                        stD = ST_SKIP;
                    end
                end
                ST_ADDR: begin
                    if (cnt_q == 2'd3) begin
                        if (hit == '0) begin
                            stD = ST_SKIP;
                        end else begin
                            stD = isWr_q ? ST_WDATA : ST_HTAR;
                        end
                    end
                end
                ST_WDATA: begin
                    if (cnt_q == 2'd1) begin
                        stD = ST_HTAR;
                    end
                end
                ST_HTAR:  stD = ST_FLT;
                ST_FLT:   stD = ST_SYNC;
                ST_SYNC:  stD = isWr_q ? ST_REC : ST_RDATA;
                ST_RDATA: begin
                    if (cnt_q == 2'd1) begin
                        stD = ST_REC;
                    end
                end
                ST_REC:   stD = ST_IDLE;
                ST_IDLE:  stD = ST_IDLE;
                ST_SKIP:  stD = ST_SKIP;
                default:  stD = ST_IDLE;
            endcase
        end
    end

    // Effects land only on entry to the state 12 turnaround
    assign commit = lclkRise && stD == ST_REC && st_q != ST_REC;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q  <= ST_IDLE;
            cnt_q <= 2'd0;
        end else if (lclkRise) begin
            st_q  <= stD;
            cnt_q <= (stD != st_q) ? 2'd0 : cnt_q + 2'd1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_q  <= 16'h0000;
            isWr_q  <= 1'b0;
            wByte_q <= 8'h00;
        end else if (lclkRise && !frameLow) begin
            if (st_q == ST_TYPE) begin
                isWr_q <= ladNib == NIB_IO_WR;
            end
            if (st_q == ST_ADDR) begin
                addr_q <= addrFull;
            end
            if (st_q == ST_WDATA && cnt_q == 2'd0) begin
                wByte_q[3:0] <= ladNib;
            end
            if (st_q == ST_WDATA && cnt_q == 2'd1) begin
                wByte_q[7:4] <= ladNib;
            end
        end
    end

    // Read byte is captured at decode so the data states need no mux race
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            chSel_q <= 1'b0;
            isCmd_q <= 1'b0;
            rByte_q <= 8'h00;
        end else if (lclkRise && !frameLow && addrDone && hit != '0) begin
            chSel_q <= hit[1];
            isCmd_q <= addrFull[2];
            rByte_q <= addrFull[2] ? strB[hit[1]] : odr_q[hit[1]];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_q <= 1'b0;
        end else if (lclkRise && frameLow) begin
            busy_q <= 1'b0;
        end else if (commit) begin
            busy_q <= 1'b0;
        end else if (lclkRise && addrDone && hit != '0) begin
            busy_q <= 1'b1;
        end
    end

    // Drive set up for the state being entered
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ladOut_q <= 4'h0;
            ladOeN_q <= 1'b1;
        end else if (lclkRise) begin
            ladOeN_q <= 1'b0;
            case (stD)
                ST_SYNC:  ladOut_q <= NIB_SYNC;
                ST_RDATA: ladOut_q <= (st_q == ST_RDATA) ? rByte_q[7:4] : rByte_q[3:0];
                ST_REC:   ladOut_q <= NIB_REC;
                default: begin
                    ladOut_q <= 4'h0;
                    ladOeN_q <= 1'b1;
                end
            endcase
        end
    end

    // Channel registers
    generate
        for (genvar c = 0; c < NCH; c++) begin : g_ch
            localparam logic [7:0] A_IDR  = 8'(CH_BASE + c * CH_STRIDE + CH_IDR);
            localparam logic [7:0] A_ODR  = 8'(CH_BASE + c * CH_STRIDE + CH_ODR);
            localparam logic [7:0] A_STR  = 8'(CH_BASE + c * CH_STRIDE + CH_STR);
            localparam logic [7:0] A_BASE = 8'(REG_BASE + 4 * c);
            localparam logic [15:0] B_RST = (c == 0) ? BASE1_RST : BASE2_RST;
            logic swRdIdr;
            logic swWrOdr;

            assign hostWr[c]     = commit && isWr_q && chSel_q == 1'(c);
            assign hostRdData[c] = commit && !isWr_q && !isCmd_q && chSel_q == 1'(c);
            // Only channel 1 can be absorbed by the gate decoder
            assign deliver[c]    = hostWr[c] && !(c == 0 && a20Absorb);
            assign swRdIdr       = regRe && regAddr == A_IDR;
            assign swWrOdr       = regWe && regAddr == A_ODR;

            always_comb begin
                strB[c] = 8'h00;
                strB[c][STR_OBF] = obf_q[c];
                strB[c][STR_IBF] = ibf_q[c];
                strB[c][STR_CD]  = cd_q[c];
            end

            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    idr_q[c] <= 8'h00;
                    cd_q[c]  <= 1'b0;
                end else if (deliver[c]) begin
                    idr_q[c] <= wByte_q;
                    cd_q[c]  <= isCmd_q;
                end
            end

            // Host events win over a same-cycle software clear
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    ibf_q[c] <= 1'b0;
                end else if (deliver[c]) begin
                    ibf_q[c] <= 1'b1;
                end else if (swRdIdr) begin
                    ibf_q[c] <= 1'b0;
                end
            end

            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    obf_q[c] <= 1'b0;
                    odr_q[c] <= 8'h00;
                end else if (swWrOdr) begin
                    obf_q[c] <= 1'b1;
                    odr_q[c] <= regWdata[7:0];
                end else if (hostRdData[c]) begin
                    obf_q[c] <= 1'b0;
                end
            end

            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    base_q[c] <= B_RST;
                end else if (regWe && regAddr == A_BASE) begin
                    base_q[c] <= regWdata[15:0];
                end
            end

            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    irqSt_q[c] <= 1'b0;
                end else if (deliver[c]) begin
                    irqSt_q[c] <= 1'b1;
                end else if (irqRd) begin
                    irqSt_q[c] <= 1'b0;
                end
            end

            always_comb begin
                chRd[c] = 32'h0000_0000;
                if (regAddr == A_IDR) begin
                    chRd[c][7:0] = idr_q[c];
                end else if (regAddr == A_ODR) begin
                    chRd[c][7:0] = odr_q[c];
                end else if (regAddr == A_STR) begin
                    chRd[c][7:0] = strB[c];
                end else if (regAddr == A_BASE) begin
                    chRd[c][15:0] = base_q[c];
                end
            end
        end
    endgenerate

    // Gate decoder sees only channel 1 host writes
    lia_fast_a20 u_a20 (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .enable  (ctrl_q[CTRL_FA20]),
        .wrStb   (hostWr[0]),
        .isCmd   (isCmd_q),
        .data    (wByte_q),
        .absorb  (a20Absorb),
        .gate    (a20Gate)
    );

    // Local control and mask
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q   <= CTRL_RST;
            irqMsk_q <= '0;
        end else if (regWe && regAddr == REG_CTRL) begin
            ctrl_q <= regWdata[3:0];
        end else if (regWe && regAddr == REG_IRQMSK) begin
            irqMsk_q <= regWdata[NCH-1:0];
        end
    end

    assign irqRd = regRe && regAddr == REG_IRQST;

    always_comb begin
        rdMux = 32'h0000_0000;
        case (regAddr)
            REG_CTRL:   rdMux[3:0] = ctrl_q;
            REG_IRQST:  rdMux[NCH-1:0] = irqSt_q;
            REG_IRQMSK: rdMux[NCH-1:0] = irqMsk_q;
            REG_STAT: begin
                rdMux[STAT_GATE] = a20Gate;
                rdMux[STAT_BUSY] = busy_q;
            end
            default: begin
                for (int c = 0; c < NCH; c++) begin
                    rdMux = rdMux | chRd[c];
                end
            end
        endcase
    end

    // Unmapped reads return zero
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdata_q <= 32'h0000_0000;
        end else begin
            regRdata_q <= regRe ? rdMux : 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            a20Pin_q <= 1'b0;
        end else begin
            a20Pin_q <= ctrl_q[CTRL_FA20] ? a20Gate : ctrl_q[CTRL_PORT];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irqSt_q & irqMsk_q);
        end
    end

    assign regRdata   = regRdata_q;
    assign ladOut     = ladOut_q;
    assign ladOeN     = ladOeN_q;
    assign a20PortPin = a20Pin_q;
    assign irq        = irq_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence sRecEntry;
        st_q == ST_REC && $past(st_q) != ST_REC;
    endsequence
    sequence sRecDrive;
        ladOut_q == NIB_REC && !ladOeN_q;
    endsequence

    AST_OTHER_TYPES_SKIPPED: assert property (
        lclkRise && !frameLow && st_q == ST_TYPE && ladNib != NIB_IO_RD && ladNib != NIB_IO_WR
        |=> st_q == ST_SKIP) else $error("foreign cycle type not skipped");
    AST_START_DECODE: assert property (
        lclkRise && frameLow && ladNib == NIB_START |=> st_q == ST_TYPE)
        else $error("start not taken");
    AST_ABORT_RELEASE: assert property (
        lclkRise && frameLow |=> ladOeN_q && !busy_q) else $error("abort left bus driven");
    AST_SYNC_ZERO: assert property (
        st_q == ST_SYNC |-> ladOut_q == NIB_SYNC && !ladOeN_q) else $error("sync not zero");
    AST_REC_THEN_FLOAT: assert property (
        sRecEntry |-> sRecDrive ##[1:20] ladOeN_q) else $error("recovery not followed by float");
    AST_BUSY_ENDS: assert property (
        commit |=> !busy_q) else $error("busy kept after turnaround");
    AST_IBF_AT_COMMIT: assert property (
        $rose(ibf_q[0]) |-> $past(commit)) else $error("flag set outside state 12");
    AST_PIN_FOLLOWS_GATE: assert property (
        ctrl_q[CTRL_FA20] |=> a20Pin_q == $past(a20Gate)) else $error("pin not from gate");
    AST_GATE_SOURCE: assert property (
        $changed(a20Gate) |-> $past(hostWr[0])) else $error("gate moved without ch1 write");
    AST_OTHER_CMD_FULL: assert property (
        hostWr[0] && isCmd_q && wByte_q != CMD_A20 && wByte_q != CMD_NULL |=> ibf_q[0])
        else $error("other command did not set input full");
    AST_SKIP_FLOATS: assert property (
        st_q == ST_SKIP |-> ladOeN_q) else $error("unmatched cycle drove bus");
endmodule : lia_lpc_io_slave
`default_nettype wire

// file: lia_lpc_io_slave_test.sv
// Self-checking bench for the LPC I/O slave with fast A20 gate
`timescale 1ns/1ps
`default_nettype none
module lia_lpc_io_slave_test
    import lia_pkg::*;
;
    logic        sys_clk;
    logic        arst_n;
    logic [7:0]  regAddr;
    logic [31:0] regWdata;
    logic        regWe;
    logic        regRe;
    logic [31:0] regRdata;
    logic        lclk;
    logic        lframeN;
    logic [3:0]  ladIn;
    logic [3:0]  ladOut;
    logic        ladOeN;
    logic        a20PortPin;
    logic        irq;
    int          mismatches = 0;
    int          cmpCount = 0;
    lia_lpc_io_slave uut (.sys_clk, .arst_n, .regAddr, .regWdata, .regWe, .regRe, .regRdata,
        .lclk, .lframeN, .ladIn, .ladOut, .ladOeN, .a20PortPin, .irq);
    lia_lpc_host host (.lclk, .lframeN, .ladIn, .ladOut, .ladOeN);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmpCount++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic pin(input logic e);
        chk("pin", 32'(e), 32'(a20PortPin));
    endtask : pin
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWe <= 1'b1;
        @(posedge sys_clk);
        regWe <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask : wreg
    task automatic rreg(input logic [7:0] a, input logic [31:0] e, input string n);
        @(posedge sys_clk);
        regAddr <= a;
        regRe <= 1'b1;
        @(posedge sys_clk);
        regRe <= 1'b0;
        #1;
        chk(n, e, regRdata);
    endtask : rreg
    task automatic lw(input logic [15:0] a, input logic [7:0] d);
        host.xfer(NIB_IO_WR, a, d, 0);
        chk("wsync", 32'({host.seen[11], host.seen[12], host.seen[13]}), 32'h0ff);
    endtask : lw
    task automatic lr(input logic [3:0] t, input logic [15:0] a, input logic [31:0] e, input string n);
        host.xfer(t, a, 8'h00, 0);
        chk(n, e, 32'({host.seen[9], host.seen[10], host.seen[11], host.seen[12], host.seen[13]}));
    endtask : lr
    task automatic finalReport;
        $display("checks %0d mismatches %0d", cmpCount, mismatches);
        if (mismatches == 0 && cmpCount > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finalReport
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Expected run is about 33 us
    initial begin
        #200000;
        mismatches++;
        finalReport();
    end
    initial begin
        arst_n = 1'b0;
        regAddr = 8'h00;
        regWdata = 32'h0;
        regWe = 1'b0;
        regRe = 1'b0;
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        rreg(REG_CTRL, 32'h0, "ctrl");
        rreg(REG_STAT, 32'h1, "stat");
        rreg(REG_STAT, 32'h1, "stat2");
        pin(1'b0);
        wreg(REG_CTRL, 32'h2);
        wreg(REG_IRQMSK, 32'h3);
        lw(16'h0064, CMD_A20);
        lw(16'h0060, 8'h3c);
        chk("irq", 32'h1, 32'(irq));
        rreg(REG_IRQST, 32'h1, "irqst");
        rreg(CH_BASE, 32'h3c, "host_input_data_ch1");
        rreg(REG_STAT, 32'h1, "stat");
        $display("test slow gate done");
        wreg(REG_CTRL, 32'h7);
        pin(1'b1);
        lw(16'h0064, CMD_A20);
        lw(16'h0060, 8'hfd);
        pin(1'b0);
        lw(16'h0064, CMD_NULL);
        chk("irq", 32'h0, 32'(irq));
        rreg(REG_IRQST, 32'h0, "irqst");
        lw(16'h0064, CMD_A20);
        lw(16'h0064, CMD_A20);
        lw(16'h0060, 8'h02);
        pin(1'b1);
        lw(16'h0064, CMD_A20);
        lw(16'h0064, 8'haa);
        lw(16'h0060, 8'h00);
        pin(1'b1);
        rreg(REG_IRQST, 32'h1, "irqst");
        rreg(CH_BASE, 32'h00, "host_input_data_ch1");
        lw(16'h006c, CMD_A20);
        lw(16'h0068, 8'h00);
        pin(1'b1);
        rreg(REG_IRQST, 32'h2, "irqst");
        $display("test fast gate done");
        lw(16'h0064, CMD_A20);
        host.xfer(NIB_IO_WR, 16'h0060, 8'h00, 10);
        pin(1'b1);
        rreg(REG_IRQST, 32'h0, "irqst");
        lw(16'h0060, 8'h00);
        pin(1'b0);
        wreg(REG_CTRL, 32'he);
        pin(1'b1);
        wreg(REG_CTRL, 32'hf);
        pin(1'b0);
        rreg(REG_STAT, 32'h0, "stat");
        $display("test abort done");
        wreg(CH_BASE + CH_ODR, 32'h5a);
        lr(NIB_IO_RD, 16'h0064, 32'h010ff, "hoststat");
        fork
            lr(NIB_IO_RD, 16'h0060, 32'h0a5ff, "read");
            begin
                // Lands between the address match and the turnaround
                repeat (8) @(posedge lclk);
                rreg(REG_STAT, 32'h2, "busyset");
            end
        join
        rreg(REG_STAT, 32'h0, "busy");
        rreg(CH_BASE + CH_STR, 32'h0, "obf");
        lr(NIB_IO_RD, 16'h0080, 32'hfffff, "miss");
        lr(4'h4, 16'h0060, 32'hfffff, "mem");
        $display("test reads done");
        finalReport();
    end
endmodule : lia_lpc_io_slave_test
`default_nettype wire

// file: lia_pkg.sv
// Shared constants and types for the LPC I/O slave with fast A20 gate
package lia_pkg;
    // Number of host channels, channel 1 is index 0
    localparam int NCH = 2;
    // Local register offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STAT   = 8'h04;
    localparam logic [7:0] REG_BASE   = 8'h08;
    localparam logic [7:0] REG_IRQST  = 8'h30;
    localparam logic [7:0] REG_IRQMSK = 8'h34;
    localparam logic [7:0] CH_BASE    = 8'h10;
    localparam logic [7:0] CH_STRIDE  = 8'h10;
    localparam logic [7:0] CH_IDR     = 8'h00;
    localparam logic [7:0] CH_ODR     = 8'h04;
    localparam logic [7:0] CH_STR     = 8'h08;
    // Control bits
    localparam int CTRL_FA20 = 0;
    localparam int CTRL_EN   = 1;
    localparam int CTRL_PORT = 3;
    localparam logic [3:0] CTRL_RST = 4'h0;
    // Status bits
    localparam int STAT_GATE = 0;
    localparam int STAT_BUSY = 1;
    // Host status byte bits
    localparam int STR_OBF = 0;
    localparam int STR_IBF = 1;
    localparam int STR_CD  = 3;
    // Host address reset values
    localparam logic [15:0] BASE1_RST = 16'h0060;
    localparam logic [15:0] BASE2_RST = 16'h0068;
    // Link nibbles
    localparam logic [3:0] NIB_START = 4'h0;
    localparam logic [3:0] NIB_IO_RD = 4'h0;
    localparam logic [3:0] NIB_IO_WR = 4'h2;
    localparam logic [3:0] NIB_SYNC  = 4'h0;
    localparam logic [3:0] NIB_REC   = 4'hf;
    // Gate commands
    localparam logic [7:0] CMD_A20   = 8'hd1;
    localparam logic [7:0] CMD_NULL  = 8'hff;
    localparam int         A20_BIT   = 1;
    localparam logic       GATE_RST  = 1'b1;
    typedef enum logic [3:0] {
        ST_IDLE, ST_TYPE, ST_ADDR, ST_WDATA, ST_HTAR,
        ST_FLT, ST_SYNC, ST_RDATA, ST_REC, ST_SKIP
    } lia_st_e;
    typedef enum logic [1:0] {A_IDLE, A_WAIT, A_DONE} lia_a20_e;
endpackage : lia_pkg
